// ==== ciod_map.svh ====
/*
  Holds the opcode-map constants of the instruction fetch and decode front end.
  Assumes it is included by bare name from the package and the decoder module.
*/
`ifndef CIOD_MAP_SVH
`define CIOD_MAP_SVH
`define CIOD_PC_RESET      16'h0000
`define CIOD_RAM_TOP       8'h7f
`define CIOD_IND_MASK      8'hfe
`define CIOD_IND_CODE      8'h06
`define CIOD_LJMP          8'h02
`define CIOD_LCALL         8'h12
`define CIOD_MOV_DPTR      8'h90
`define CIOD_SJMP          8'h80
`define CIOD_JMP_INDIRECT  8'h73
`define CIOD_CJNE_LO       8'hb4
`define CIOD_CJNE_HI       8'hbf
`define CIOD_DJNZ_R_LO     8'hd8
`define CIOD_DJNZ_R_HI     8'hdf
`define CIOD_DJNZ_DIR      8'hd5
`define CIOD_MOV_DIR_DIR   8'h85
`define CIOD_MOV_DIR_IMM   8'h75
`define CIOD_LO_NIB_MASK   8'h0f
`define CIOD_AJMP_MASK     8'h1f
`define CIOD_AJMP_CODE     8'h01
`define CIOD_PAGE_LO       11
`endif

// ==== ciod_pkg.sv ====
/*
  Holds the types of the instruction fetch and decode front end.
  Assumes the map header sits in the same folder.
*/
`include "ciod_map.svh"
package ciod_pkg;
  typedef enum logic [3:0] {
    CIOD_S_OPCODE = 4'b0001,
    CIOD_S_OPND1  = 4'b0010,
    CIOD_S_OPND2  = 4'b0100,
    CIOD_S_DONE   = 4'b1000
  } ciod_state_type;

  typedef enum logic [3:0] {
    CIOD_MODE_NONE     = 4'h0,
    CIOD_MODE_BANK     = 4'h1,
    CIOD_MODE_DIRECT   = 4'h2,
    CIOD_MODE_INDIRECT = 4'h3,
    CIOD_MODE_IMM8     = 4'h4,
    CIOD_MODE_IMM16    = 4'h5,
    CIOD_MODE_LONG     = 4'h6,
    CIOD_MODE_PAGE     = 4'h7,
    CIOD_MODE_REL      = 4'h8,
    CIOD_MODE_BIT      = 4'h9
  } ciod_mode_type;

  typedef struct packed {
    logic [7:0]    opcode;
    logic [1:0]    length;
    ciod_mode_type mode;
    logic [2:0]    bank_register_operand;
    logic          indirect_pointer_operand;
    logic          direct_is_sfr;
    logic [7:0]    direct_address;
    logic [7:0]    bit_address;
    logic [15:0]   word_immediate;
    logic [15:0]   target;
  } ciod_decode_type;
endpackage : ciod_pkg

// ==== ciod_decoder.sv ====
/*
  Holds the instruction fetch and decode front end: it pulls an opcode and its
  operand bytes from program memory and resolves the addressing form.
  Assumes program memory answers a read request with data one cycle later and
  that the core pulses NEXT once it has taken a decoded instruction.
*/
//
// Contract
// - The first byte of every instruction is one 8-bit opcode that is the full operation code.
// - The opcode is read from program memory before decoding begins.
// - Decoding yields the operation and whether further operand bytes follow.
// - Exactly one, two or three bytes are fetched as the opcode requires.
// - A bank register operand picks one of eight registers of the selected bank.
// - A direct address below 128 is internal RAM, 128 and up is SFR space.
// - An indirect operand uses working register zero or one as a RAM address.
// - Immediates come from the instruction bytes, one byte or two bytes.
// - Long call and jump take a full 16-bit target.
// - Absolute call and jump replace the low 11 bits within the page of the next byte; the code does this for absolute jump only.
// - Relative branches add a signed 8-bit offset to the next instruction address.
// - A bit operand is a direct bit address in RAM or SFR space.
`timescale 1ns/1ps
`include "ciod_map.svh"
module ciod_decoder
  import ciod_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic                CLK,        // 50 MHz clock
  input  wire logic                NRST,       // Asynchronous reset, active low
  output      logic                MEM_RD,     // Program memory read request
  output      logic [ADDR_W-1:0]   MEM_ADDR,   // Program memory byte address
  input  wire logic [7:0]          MEM_DATA,   // Byte returned one cycle after request
  input  wire logic                NEXT,       // Core took the decoded instruction
  output      logic                VALID,      // Decoded instruction held
  output      ciod_decode_type     DECODE,     // Decoded fields
  output      logic [ADDR_W-1:0]   NEXT_PC     // Address of the following instruction
);

  ciod_state_type        state_reg, state_next;
  logic [ADDR_W-1:0]     pc_reg;
  logic                  wait_reg;
  logic [7:0]            op_reg;
  logic [7:0]            b1_reg;
  logic [1:0]            len_reg;

  // Opcode length in bytes
  function automatic logic [1:0] op_length(input logic [7:0] op);
    logic [3:0] lo;
    lo = op[3:0];
    if (op == `CIOD_LJMP || op == `CIOD_LCALL || op == `CIOD_MOV_DPTR ||
        op == `CIOD_MOV_DIR_DIR || op == `CIOD_MOV_DIR_IMM ||
        op == `CIOD_DJNZ_DIR ||
        (op >= `CIOD_CJNE_LO && op <= `CIOD_CJNE_HI))
      return 2'd3;
    if ((op & `CIOD_AJMP_MASK) == `CIOD_AJMP_CODE)
      return 2'd2;
    if (op[7:4] <= 4'h3 && lo == 4'h0)
      return (op[7:4] == 4'h0) ? 2'd1 : 2'd3;
    if (op[7:4] >= 4'h4 && op[7:4] <= 4'h7 && (lo == 4'h2 || lo == 4'h3))
      return (lo == 4'h3) ? 2'd3 : 2'd2;
    if (op[7:4] >= 4'h4 && op[7:4] <= 4'h7 && lo == 4'h0)
      return 2'd2;
    if (op == `CIOD_JMP_INDIRECT)
      return 2'd1;
    if (op[7:4] >= 4'h8 && op[7:4] <= 4'hd && lo == 4'h2)
      return 2'd2;
    if (op == 8'hc0 || op == 8'hd0 || op == 8'hc2 || op == 8'hd2 ||
        op == 8'hb2 || op == 8'hc5 || op == 8'hb0 || op == 8'ha0 ||
        op == 8'h80 || op == 8'h90)
      return 2'd2;
    if (op[7:4] >= 4'h8 && op[7:4] <= 4'hb && lo == 4'h0)
      return 2'd2;
    if (lo == 4'h4 && op[7:4] >= 4'h2 && op[7:4] <= 4'h9 && op[7:4] != 4'h8)
      return 2'd2;
    if (lo == 4'h5 && op[7:4] != 4'h8)
      return 2'd2;
    if (op[7:4] == 4'h7 && op[3])
      return 2'd2;
    if (op[7:4] == 4'h7 && lo >= 4'h6)
      return 2'd2;
    if (op[7:4] == 4'h8 && lo >= 4'h6)
      return 2'd2;
    if (op[7:4] == 4'ha && lo >= 4'h6)
      return 2'd2;
    if ((op[7:4] == 4'hd) && op[3])
      return 2'd2;
    return 2'd1;
  endfunction : op_length

  // Addressing form of the opcode
  function automatic ciod_mode_type op_mode(input logic [7:0] op);
    if (op == `CIOD_LJMP || op == `CIOD_LCALL)
      return CIOD_MODE_LONG;
    if ((op & `CIOD_AJMP_MASK) == `CIOD_AJMP_CODE)
      return CIOD_MODE_PAGE;
    if (op == `CIOD_MOV_DPTR)
      return CIOD_MODE_IMM16;
    if (op == `CIOD_SJMP || (op[3:0] == 4'h0 && op[7:4] >= 4'h4 && op[7:4] <= 4'h7) ||
        (op >= `CIOD_DJNZ_R_LO && op <= `CIOD_DJNZ_R_HI))
      return CIOD_MODE_REL;
    if ((op >= `CIOD_CJNE_LO && op <= `CIOD_CJNE_HI) || op == `CIOD_DJNZ_DIR)
      return CIOD_MODE_REL;
    if ((op[3:0] == 4'h0 && op[7:4] <= 4'h3 && op != 8'h00) ||
        op == 8'h82 || op == 8'h92 || op == 8'ha2 || op == 8'hb2 ||
        op == 8'hc2 || op == 8'hd2 || op == 8'h72 || op == 8'ha0 || op == 8'hb0)
      return CIOD_MODE_BIT;
    if (op[3])
      return CIOD_MODE_BANK;
    if ((op & `CIOD_IND_MASK) == `CIOD_IND_CODE ||
        (op[3:1] == 3'b011 && op[7:4] >= 4'h0))
      return CIOD_MODE_INDIRECT;
    if (op[3:0] == 4'h4 && op[7:4] >= 4'h2 && op[7:4] <= 4'h9)
      return CIOD_MODE_IMM8;
    if (op[3:0] == 4'h5)
      return CIOD_MODE_DIRECT;
    return CIOD_MODE_NONE;
  endfunction : op_mode

  logic [ADDR_W-1:0] rel_target;
  logic [ADDR_W-1:0] page_target;
  logic [7:0]        last_byte;

  logic [ADDR_W-1:0] after_pc;

  // The last operand byte is on the bus in the cycle that finishes the fetch
  assign last_byte   = MEM_DATA;
  assign after_pc    = ADDR_W'(pc_reg + ADDR_W'(1));
  assign rel_target  = ADDR_W'(after_pc +
                       {{(ADDR_W-8){last_byte[7]}}, last_byte});
  // Page bits come from the address after the instruction, not the operand byte
  assign page_target = {after_pc[ADDR_W-1:`CIOD_PAGE_LO], op_reg[7:5], last_byte};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CIOD_S_OPCODE: if (wait_reg) state_next = (op_length(MEM_DATA) == 2'd1) ?
                                   CIOD_S_DONE : CIOD_S_OPND1;
      CIOD_S_OPND1:  if (wait_reg) state_next = (len_reg == 2'd3) ? CIOD_S_OPND2 : CIOD_S_DONE;
      CIOD_S_OPND2:  if (wait_reg) state_next = CIOD_S_DONE;
      CIOD_S_DONE:   if (NEXT) state_next = CIOD_S_OPCODE;
      default:       state_next = CIOD_S_OPCODE;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) state_reg <= CIOD_S_OPCODE;
    else       state_reg <= state_next;
  end

  // Request then wait one cycle for each byte
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wait_reg <= 1'b0;
      MEM_RD   <= 1'b0;
      MEM_ADDR <= '0;
      pc_reg   <= `CIOD_PC_RESET;
    end else if (state_reg != CIOD_S_DONE && !wait_reg && !MEM_RD) begin
      MEM_RD   <= 1'b1;
      MEM_ADDR <= pc_reg;
    end else if (MEM_RD) begin
      MEM_RD   <= 1'b0;
      wait_reg <= 1'b1;
    end else if (wait_reg) begin
      wait_reg <= 1'b0;
      if (state_next != CIOD_S_DONE || state_reg != CIOD_S_DONE)
        pc_reg <= ADDR_W'(pc_reg + ADDR_W'(1));
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      op_reg  <= 8'h00;
      b1_reg  <= 8'h00;
      len_reg <= 2'd1;
    end else if (wait_reg && state_reg == CIOD_S_OPCODE) begin
      op_reg  <= MEM_DATA;
      len_reg <= op_length(MEM_DATA);
    end else if (wait_reg && state_reg == CIOD_S_OPND1) begin
      b1_reg  <= MEM_DATA;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      VALID   <= 1'b0;
      DECODE  <= '0;
      NEXT_PC <= `CIOD_PC_RESET;
    end else if (state_reg == CIOD_S_DONE) begin
      if (NEXT) VALID <= 1'b0;
    end else if (wait_reg && state_next == CIOD_S_DONE) begin
      VALID                           <= 1'b1;
      NEXT_PC                         <= ADDR_W'(pc_reg + ADDR_W'(1));
      DECODE.opcode                   <= (state_reg == CIOD_S_OPCODE) ? MEM_DATA : op_reg;
      DECODE.length                   <= (state_reg == CIOD_S_OPCODE) ? 2'd1 : len_reg;
      DECODE.mode                     <= op_mode((state_reg == CIOD_S_OPCODE) ? MEM_DATA : op_reg);
      DECODE.bank_register_operand    <= ((state_reg == CIOD_S_OPCODE) ? MEM_DATA[2:0]
                                          : op_reg[2:0]);
      DECODE.indirect_pointer_operand <= ((state_reg == CIOD_S_OPCODE) ? MEM_DATA[0]
                                          : op_reg[0]);
      DECODE.direct_address           <= (state_reg == CIOD_S_OPCODE) ? 8'h00 :
                                         (state_reg == CIOD_S_OPND1) ? MEM_DATA : b1_reg;
      DECODE.direct_is_sfr            <= (state_reg != CIOD_S_OPCODE) &&
                                         (((state_reg == CIOD_S_OPND1) ? MEM_DATA : b1_reg)
                                          > `CIOD_RAM_TOP);
      DECODE.bit_address              <= (state_reg == CIOD_S_OPND1) ? MEM_DATA : b1_reg;
      DECODE.word_immediate           <= (state_reg == CIOD_S_OPND2) ? {b1_reg, MEM_DATA}
                                         : {8'h00, MEM_DATA};
      if (state_reg == CIOD_S_OPND2 &&
          (op_reg == `CIOD_LJMP || op_reg == `CIOD_LCALL))
        DECODE.target <= 16'({b1_reg, MEM_DATA});
      else if (state_reg == CIOD_S_OPND1 && (op_reg & `CIOD_AJMP_MASK) == `CIOD_AJMP_CODE)
        DECODE.target <= 16'(page_target);
      else if (op_mode(op_reg) == CIOD_MODE_REL && state_reg != CIOD_S_OPCODE)
        DECODE.target <= 16'(rel_target);
      else
        DECODE.target <= 16'h0000;
    end
  end

endmodule : ciod_decoder

// ==== ciod_decoder_chk.sv ====
/* Checker for the fetch and decode front end.
   Assumes it is bound to ciod_decoder and sees only its ports. */
`timescale 1ns/1ps
module ciod_decoder_chk
  import ciod_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic                  CLK,      // Clock
  input wire logic                  NRST,     // Reset, active low
  input wire logic                  MEM_RD,   // Read request
  input wire logic [ADDR_W-1:0]     MEM_ADDR, // Fetch address
  input wire logic [7:0]            MEM_DATA, // Fetched byte
  input wire logic                  NEXT,     // Core take
  input wire logic                  VALID,    // Decode held
  input wire ciod_decode_type       DECODE,   // Decoded fields
  input wire logic [ADDR_W-1:0]     NEXT_PC   // Following address
);
  logic [ADDR_W-1:0] last_reg;
  logic              seen_reg;
  // Last fetched address
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      last_reg <= '0;
      seen_reg <= 1'b0;
    end else if (MEM_RD) begin
      last_reg <= MEM_ADDR;
      seen_reg <= 1'b1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_rd_spacing: assert property (MEM_RD |=> !MEM_RD ##1 !MEM_RD)
    else $error("read request not spaced");
  a_first_fetch: assert property (MEM_RD && !seen_reg |-> MEM_ADDR == '0)
    else $error("first fetch not at zero");
  a_addr_step: assert property (MEM_RD && seen_reg |-> MEM_ADDR == last_reg + 1'b1)
    else $error("fetch address skipped");
  a_no_fetch_held: assert property (VALID |-> !MEM_RD)
    else $error("fetch while decode held");
  a_valid_hold: assert property (VALID && !NEXT |=> VALID && $stable(DECODE))
    else $error("decode not held");
  a_valid_drop: assert property (VALID && NEXT |=> !VALID)
    else $error("decode not released");
  a_length_ok: assert property (VALID |-> DECODE.length inside {2'd1, 2'd2, 2'd3})
    else $error("bad length");
  a_next_pc: assert property ($rose(VALID) |-> NEXT_PC == last_reg + 1'b1)
    else $error("next address wrong");
  a_sfr_split: assert property (VALID && DECODE.mode == CIOD_MODE_DIRECT |->
    DECODE.direct_is_sfr == DECODE.direct_address[7])
    else $error("direct space wrong");
  a_bank_index: assert property (VALID && DECODE.mode == CIOD_MODE_BANK |->
    DECODE.bank_register_operand == DECODE.opcode[2:0])
    else $error("bank index wrong");
  c_three: cover property ($rose(VALID) && DECODE.length == 2'd3);
  c_take: cover property (VALID && NEXT);
  c_rel: cover property (VALID && DECODE.mode == CIOD_MODE_REL);
endmodule : ciod_decoder_chk

// ==== ciod_progmem.sv ====
/* Program memory model.
   Assumes a read is answered in the cycle after the request. */
`timescale 1ns/1ps
module ciod_progmem (
  input  wire logic        clk,  // Clock
  input  wire logic        rd,   // Read request
  input  wire logic [15:0] addr, // Byte address
  output      logic [7:0]  data  // Read byte
);
  logic [7:0] mem [0:255];
  initial data = 8'h00;
  // Outside the answer cycle the bus inverts its previous value every cycle
  always @(posedge clk) begin
    if (rd) data <= #1 mem[addr[7:0]];
    else data <= #1 ~data;
  end
endmodule : ciod_progmem

// ==== cpu_instruction_operand_decode_bench.sv ====
/* Bench for the fetch and decode front end.
   Assumes the program memory model and checker files. */
`timescale 1ns/1ps
module cpu_instruction_operand_decode_bench;
  import ciod_pkg::*;
  logic            clk = 1'b0;
  logic            nrst = 1'b0;
  logic            next = 1'b0;
  logic            mem_rd;
  logic [15:0]     mem_addr;
  logic [7:0]      mem_data;
  logic            valid;
  ciod_decode_type dec;
  logic [15:0]     next_pc;
  logic [15:0]     pc = 16'h0000;
  int              err_count = 0;
  int              tests_run = 0;
  logic [7:0]      prog [0:20] = '{8'h2d, 8'h27, 8'h25, 8'h80, 8'h35, 8'h7f, 8'h24,
    8'h5a, 8'h90, 8'h12, 8'h34, 8'h02, 8'hab, 8'hcd, 8'he1, 8'h23, 8'h80, 8'hfe,
    8'hd2, 8'h9a, 8'h00};
  always #10 clk = ~clk;
  ciod_decoder #(.ADDR_W(16)) i_ciod_decoder (.CLK(clk), .NRST(nrst), .MEM_RD(mem_rd),
    .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .NEXT(next), .VALID(valid),
    .DECODE(dec), .NEXT_PC(next_pc));
  ciod_progmem i_ciod_progmem (.clk(clk), .rd(mem_rd), .addr(mem_addr), .data(mem_data));
  task chk(string nm, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task take(ciod_mode_type md, logic [1:0] len);
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("opcode", {8'h00, prog[pc]}, {8'h00, dec.opcode});
    chk("length", {14'h0, len}, {14'h0, dec.length});
    chk("mode", {12'h0, md}, {12'h0, dec.mode});
    chk("next_pc", pc + len, next_pc);
  endtask : take
  task give;
    next = 1'b1;
    @(posedge clk);
    #1;
    next = 1'b0;
    pc = pc + dec.length;
  endtask : give
  task t_bank;
    take(CIOD_MODE_BANK, 2'd1);
    chk("bank", 16'h5, {13'h0, dec.bank_register_operand});
    give;
    take(CIOD_MODE_INDIRECT, 2'd1);
    chk("pointer", 16'h1, {15'h0, dec.indirect_pointer_operand});
    give;
  endtask : t_bank
  task t_direct;
    take(CIOD_MODE_DIRECT, 2'd2);
    chk("sfr", 16'h180, {7'h0, dec.direct_is_sfr, dec.direct_address});
    give;
    take(CIOD_MODE_DIRECT, 2'd2);
    chk("ram", 16'h07f, {7'h0, dec.direct_is_sfr, dec.direct_address});
    give;
  endtask : t_direct
  task t_imm;
    take(CIOD_MODE_IMM8, 2'd2);
    give;
    take(CIOD_MODE_IMM16, 2'd3);
    chk("word", 16'h1234, dec.word_immediate);
    give;
  endtask : t_imm
  task t_jump;
    take(CIOD_MODE_LONG, 2'd3);
    chk("long", 16'habcd, dec.target);
    give;
    take(CIOD_MODE_PAGE, 2'd2);
    chk("page", 16'h0723, dec.target);
    give;
  endtask : t_jump
  task t_rel;
    take(CIOD_MODE_REL, 2'd2);
    chk("rel", 16'h0010, dec.target);
    give;
  endtask : t_rel
  task t_bit;
    take(CIOD_MODE_BIT, 2'd2);
    chk("bit", 16'h009a, {8'h00, dec.bit_address});
    give;
    take(CIOD_MODE_NONE, 2'd1);
    give;
  endtask : t_bit
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    for (int i = 0; i < 256; i++) i_ciod_progmem.mem[i] = (i < 21) ? prog[i] : 8'h00;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_bank;
    t_direct;
    t_imm;
    t_jump;
    t_rel;
    t_bit;
    close_out;
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    close_out;
  end
endmodule : cpu_instruction_operand_decode_bench
bind ciod_decoder ciod_decoder_chk #(.ADDR_W(ADDR_W)) i_ciod_decoder_chk (.CLK(CLK),
  .NRST(NRST), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR), .MEM_DATA(MEM_DATA), .NEXT(NEXT),
  .VALID(VALID), .DECODE(DECODE), .NEXT_PC(NEXT_PC));
